// file: rtl/sfra_pkg.sv
package sfra_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int F14_MHZ = 14;
	localparam int F25_MHZ = 25;
	localparam int F33_MHZ = 33;
	localparam int F50_MHZ = 50;
	localparam int T20_MHZ = 20;
	localparam int T17_MHZ = 17;
	localparam int T48_MHZ = 48;

	// Period rounds up, so the clock never runs above its figure
	function automatic logic [3:0] sfra_per(input int mhz);
		return 4'((CLK_MHZ + mhz - 1) / mhz);
	endfunction

	localparam logic [3:0] PER_FLASH [0:3] = '{sfra_per(F14_MHZ), sfra_per(F25_MHZ),
		sfra_per(F33_MHZ), sfra_per(F50_MHZ)};
	localparam logic [3:0] PER_TPM [0:3] = '{sfra_per(T17_MHZ), sfra_per(F33_MHZ),
		sfra_per(T48_MHZ), sfra_per(T20_MHZ)};
	localparam logic [3:0] PER_BOOT = sfra_per(F14_MHZ);
	localparam logic [1:0] TAIL_CYC = 2'h3;

	// ----------------------------------------
	// Descriptor layout
	// ----------------------------------------
	localparam logic [26:0] SIG_OFF = 27'h10;
	localparam logic [26:0] COMPONENT_SECTION_BASE = 27'h30;
	localparam logic [26:0] REGION_SECTION_BASE = 27'h40;
	localparam logic [26:0] MASTER_SECTION_BASE = 27'h80;
	localparam logic [26:0] DEVICE_STRAP_BASE = 27'h100;
	localparam logic [26:0] MANAGEMENT_TABLE_BASE = 27'hc00;
	localparam logic [26:0] POWER_STRAP_BASE = 27'hc14;
	localparam logic [26:0] CPU_STRAP_BASE = 27'hc2c;
	localparam logic [26:0] REGISTER_INIT_BASE = 27'h340;
	localparam logic [26:0] DESC_MASK = 27'hfff;
	localparam logic [31:0] SIGNATURE = 32'h0ff0a55a;
	localparam logic [3:0] MST_FIRST = 4'h7;
	localparam logic [3:0] BOOT_LAST = 4'ha;
	localparam int RB_HI = 14;
	localparam int RL_LO = 16;
	localparam int RL_HI = 30;
	localparam int RID_HI = 15;
	localparam logic [11:0] UNIT_ZERO = 12'h000;
	localparam logic [11:0] UNIT_MAX = 12'hfff;

	// ----------------------------------------
	// Regions and masters
	// ----------------------------------------
	localparam int NREG = 6;
	localparam logic [1:0] M_HOST = 2'h0;
	localparam logic [1:0] M_MGMT = 2'h1;
	localparam logic [2:0] PRIM [0:3] = '{3'h1, 3'h2, 3'h3, 3'h5};
	localparam logic [5:0] PERM_RD [0:3] = '{6'h22, 6'h04, 6'h0e, 6'h20};
	localparam logic [5:0] PERM_WR [0:3] = '{6'h02, 6'h04, 6'h0a, 6'h20};
	localparam logic [26:0] COMP_3B = 27'h1000000;
	localparam logic [26:0] COMP_4B = 27'h4000000;

	// ----------------------------------------
	// Serial commands
	// ----------------------------------------
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DOUT = 8'h3b;
	localparam logic [7:0] OP_DIO = 8'hbb;
	localparam logic [7:0] OP_QOUT = 8'h6b;
	localparam logic [7:0] OP_QIO = 8'heb;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] TPM_RD = 8'h80;
	localparam logic [7:0] TPM_WR = 8'h00;
	localparam logic [3:0] DUM_STD = 4'h8;
	localparam logic [3:0] DUM_DIO = 4'h4;
	localparam logic [3:0] DUM_QIO = 4'h6;
	localparam logic [5:0] CMD_CLK = 6'h08;
	localparam logic [5:0] ABITS3 = 6'h18;
	localparam logic [5:0] ABITS4 = 6'h20;
	localparam logic [5:0] BYTE_BITS = 6'h08;
	localparam logic [5:0] WORD_BITS = 6'h20;
	localparam logic [1:0] LW1 = 2'h0;
	localparam logic [1:0] LW2 = 2'h1;
	localparam logic [1:0] LW4 = 2'h2;

	typedef enum logic [2:0] {RM_DOUT, RM_DIO, RM_QOUT, RM_QIO, RM_FAST} sfra_rmode_type;
	typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_TAIL} sfra_state_type;
	typedef enum logic [1:0] {K_BOOT, K_DIR, K_PROG, K_TPM} sfra_kind_type;

	typedef struct packed {
		sfra_kind_type kind;
		logic [7:0]    cmd;
		logic [31:0]   addr;
		logic [5:0]    aclk;
		logic [1:0]    alw;
		logic [3:0]    dum;
		logic [5:0]    dclk;
		logic [1:0]    dlw;
		logic          din;
		logic [7:0]    wd;
		logic [1:0]    cs;
		logic [3:0]    per;
		logic [26:0]   linear_flash_address;
	} sfra_plan_type;
endpackage

// file: rtl/sfra_ctrl.sv
module sfra_ctrl (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     req_valid,
	input  wire logic                     req_direct,
	input  wire logic                     req_write,
	input  wire logic [1:0]               req_master,
	input  wire logic [15:0]              req_rid,
	input  wire logic [26:0]              req_addr,
	input  wire logic [7:0]               req_wdata,
	input  wire logic                     tpm_req,
	input  wire logic                     tpm_write,
	input  wire logic [23:0]              tpm_addr,
	input  wire logic [7:0]               tpm_wdata,
	input  wire logic [1:0]               flash_clk_sel,
	input  wire sfra_pkg::sfra_rmode_type read_mode,
	input  wire logic                     bidir_strap,
	input  wire logic                     addr4_primary,
	input  wire logic                     addr4_secondary,
	input  wire logic                     tpm_strap_valid,
	input  wire logic [1:0]               tpm_strap_sel,
	input  wire logic [3:0]               io_in,
	output logic                          req_ready,
	output logic                          rsp_done,
	output logic                          rsp_err,
	output logic [31:0]                   rsp_data,
	output logic                          desc_done,
	output logic                          desc_valid,
	output logic                          spi_clk,
	output logic                          flash_select_primary_b,
	output logic                          flash_select_secondary_b,
	output logic                          secure_module_select_b,
	output logic [3:0]                    io_out,
	output logic [3:0]                    io_oe
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic in_reg(input logic [26:0] a, input logic [14:0] b, input logic [14:0] l);
		return (l >= b) && (a >= {b, sfra_pkg::UNIT_ZERO}) && (a <= {l, sfra_pkg::UNIT_MAX});
	endfunction

	function automatic logic [31:0] swap32(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	function automatic logic [31:0] shin(input logic [31:0] s, input logic [1:0] lw, input logic [3:0] io);
		case (lw)
			sfra_pkg::LW1: return {s[30:0], io[1]};
			sfra_pkg::LW2: return {s[29:0], io[1:0]};
			default: return {s[27:0], io};
		endcase
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] lw);
		case (lw)
			sfra_pkg::LW1: return 4'h1;
			sfra_pkg::LW2: return 4'h3;
			default: return 4'hf;
		endcase
	endfunction

	function automatic logic [26:0] boot_addr(input logic [3:0] i);
		if (i == 4'h0)
			return sfra_pkg::SIG_OFF;
		if (i < sfra_pkg::MST_FIRST)
			return 27'(sfra_pkg::REGION_SECTION_BASE + {21'h0, 4'(i - 4'h1), 2'h0});
		return 27'(sfra_pkg::MASTER_SECTION_BASE + {21'h0, 4'(i - sfra_pkg::MST_FIRST), 2'h0});
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [3:0]               io_s1, io_s2;
	sfra_pkg::sfra_state_type state, next_state;
	sfra_pkg::sfra_plan_type  plan, next_plan, fp, tp, bp;
	logic [3:0]               cnt, next_cnt, bidx, next_bidx;
	logic [5:0]               left, next_left;
	logic [1:0]               lw, next_lw, cap, next_cap, tail, next_tail;
	logic [31:0]              sh, next_sh, shi, next_shi, word;
	logic [14:0]              base [0:5], next_base [0:5], lim [0:5], next_lim [0:5];
	logic [15:0]              rid [0:3], next_rid [0:3];
	logic                     c_valid, next_c_valid;
	logic [26:0]              c_tag, next_c_tag;
	logic [31:0]              c_data, next_c_data;
	logic [1:0]               c_last, next_c_last;
	logic                     next_ready, next_done, next_err, next_dd, next_dv, next_sck;
	logic [31:0]              next_data;
	logic [2:0]               sel_b, next_sel_b;
	logic [3:0]               next_io, next_oe;
	logic [1:0]               m;
	logic [2:0]               pr;
	logic [26:0]              linear_flash_address, dev, comp0;
	logic [5:0]               hitm;
	logic                     sec, a4, cap_ok, perm_ok, dir_ok, ok, hit, rise, fall, go_data, busy, start;
	sfra_pkg::sfra_rmode_type rm;

	assign flash_select_primary_b = sel_b[0];
	assign flash_select_secondary_b = sel_b[1];
	assign secure_module_select_b = sel_b[2];

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
		end else begin
			io_s1 <= io_in;
			io_s2 <= io_s1;
		end
	end

	// ----------------------------------------
	// Access checks and transfer plans
	// ----------------------------------------
	always_comb begin
		m = req_master;
		pr = sfra_pkg::PRIM[m];
		comp0 = addr4_primary ? sfra_pkg::COMP_4B : sfra_pkg::COMP_3B;
		linear_flash_address = req_addr;
		if (req_direct && (m == sfra_pkg::M_HOST || m == sfra_pkg::M_MGMT))
			linear_flash_address = 27'({base[pr], sfra_pkg::UNIT_ZERO} + req_addr);
		sec = linear_flash_address >= comp0;
		dev = sec ? 27'(linear_flash_address - comp0) : linear_flash_address;
		a4 = sec ? addr4_secondary : addr4_primary;
		cap_ok = dev < (a4 ? sfra_pkg::COMP_4B : sfra_pkg::COMP_3B);
		hitm = 6'h00;
		for (int r = 0; r < sfra_pkg::NREG; r++) begin
			hitm[r] = in_reg(linear_flash_address, base[r], lim[r]);
		end
		perm_ok = |(hitm & (req_write ? sfra_pkg::PERM_WR[m] : sfra_pkg::PERM_RD[m]));
		// Ethernet region is only the Ethernet master's primary region
		dir_ok = !req_write && in_reg(linear_flash_address, base[pr], lim[pr]);
		// Primary region defined and requester known, for both access paths
		ok = desc_valid && req_rid == rid[m] && lim[pr] >= base[pr] && cap_ok
			&& (req_direct ? dir_ok : perm_ok);
		hit = req_direct && c_valid && c_last == m && c_tag == linear_flash_address;
		rm = bidir_strap ? read_mode : sfra_pkg::RM_FAST;
		fp = '0;
		fp.kind = req_direct ? sfra_pkg::K_DIR : sfra_pkg::K_PROG;
		fp.linear_flash_address = linear_flash_address;
		fp.cs = {1'b0, sec};
		fp.per = sfra_pkg::PER_FLASH[flash_clk_sel];
		fp.addr = a4 ? {5'h0, dev} : {dev[23:0], 8'h00};
		fp.cmd = sfra_pkg::OP_FAST;
		fp.dum = sfra_pkg::DUM_STD;
		fp.din = 1'b1;
		fp.wd = req_wdata;
		// Program path trusts software not to cross a block or component
		if (req_write) begin
			fp.cmd = sfra_pkg::OP_PROG;
			fp.dum = 4'h0;
			fp.din = 1'b0;
		end else begin
			case (rm)
				sfra_pkg::RM_DOUT: begin
					fp.cmd = sfra_pkg::OP_DOUT;
					fp.dlw = sfra_pkg::LW2;
				end
				sfra_pkg::RM_DIO: begin
					fp.cmd = sfra_pkg::OP_DIO;
					fp.alw = sfra_pkg::LW2;
					fp.dlw = sfra_pkg::LW2;
					fp.dum = sfra_pkg::DUM_DIO;
				end
				sfra_pkg::RM_QOUT: begin
					fp.cmd = sfra_pkg::OP_QOUT;
					fp.dlw = sfra_pkg::LW4;
				end
				sfra_pkg::RM_QIO: begin
					fp.cmd = sfra_pkg::OP_QIO;
					fp.alw = sfra_pkg::LW4;
					fp.dlw = sfra_pkg::LW4;
					fp.dum = sfra_pkg::DUM_QIO;
				end
				default: ;
			endcase
		end
		fp.aclk = 6'((a4 ? sfra_pkg::ABITS4 : sfra_pkg::ABITS3) >> fp.alw);
		fp.dclk = 6'((req_write ? sfra_pkg::BYTE_BITS : sfra_pkg::WORD_BITS) >> fp.dlw);
		tp = '0;
		tp.kind = sfra_pkg::K_TPM;
		tp.cmd = tpm_write ? sfra_pkg::TPM_WR : sfra_pkg::TPM_RD;
		tp.addr = {tpm_addr, 8'h00};
		tp.aclk = sfra_pkg::ABITS3;
		tp.dclk = sfra_pkg::BYTE_BITS;
		tp.din = !tpm_write;
		tp.wd = tpm_wdata;
		tp.cs = 2'h2;
		tp.per = tpm_strap_valid ? sfra_pkg::PER_TPM[tpm_strap_sel] : sfra_pkg::PER_TPM[3];
		bp = '0;
		bp.kind = sfra_pkg::K_BOOT;
		bp.cmd = sfra_pkg::OP_FAST;
		bp.addr = {5'h0, boot_addr(bidx) & sfra_pkg::DESC_MASK} << 8;
		bp.aclk = sfra_pkg::ABITS3;
		bp.dum = sfra_pkg::DUM_STD;
		bp.dclk = sfra_pkg::WORD_BITS;
		bp.din = 1'b1;
		bp.per = sfra_pkg::PER_BOOT;
	end

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_plan = plan;
		next_cnt = cnt;
		next_left = left;
		next_lw = lw;
		next_sh = sh;
		next_shi = shi;
		next_tail = tail;
		next_bidx = bidx;
		next_base = base;
		next_lim = lim;
		next_rid = rid;
		next_c_valid = c_valid;
		next_c_tag = c_tag;
		next_c_data = c_data;
		next_c_last = c_last;
		next_done = 1'b0;
		next_err = 1'b0;
		next_data = rsp_data;
		next_dd = desc_done;
		next_dv = desc_valid;
		next_sck = spi_clk;
		next_sel_b = sel_b;
		go_data = 1'b0;
		start = 1'b0;
		word = plan.kind == sfra_pkg::K_TPM ? {24'h0, shi[7:0]} : swap32(shi);
		busy = state == sfra_pkg::ST_CMD || state == sfra_pkg::ST_ADDR
			|| state == sfra_pkg::ST_DUMMY || state == sfra_pkg::ST_DATA;
		rise = cnt == 4'(plan.per - (plan.per >> 1) - 4'h1);
		fall = cnt == 4'(plan.per - 4'h1);
		// Pin view lags two cycles, so capture trails each rising edge by two
		next_cap = {cap[0], busy && rise && state == sfra_pkg::ST_DATA && plan.din};
		if (cap[1])
			next_shi = shin(shi, plan.dlw, io_s2);
		if (busy) begin
			next_cnt = fall ? 4'h0 : 4'(cnt + 4'h1);
			if (rise)
				next_sck = 1'b1;
			if (fall) begin
				next_sck = 1'b0;
				next_sh = sh << (3'h1 << lw);
				next_left = 6'(left - 6'h01);
				if (left == 6'h01) begin
					case (state)
						sfra_pkg::ST_CMD: begin
							next_state = sfra_pkg::ST_ADDR;
							next_left = plan.aclk;
							next_lw = plan.alw;
							next_sh = plan.addr;
						end
						sfra_pkg::ST_ADDR: begin
							if (plan.dum != 4'h0) begin
								next_state = sfra_pkg::ST_DUMMY;
								next_left = {2'h0, plan.dum};
								next_sh = 32'h0;
							end else begin
								go_data = 1'b1;
							end
						end
						sfra_pkg::ST_DUMMY: go_data = 1'b1;
						default: begin
							next_state = sfra_pkg::ST_TAIL;
							next_tail = sfra_pkg::TAIL_CYC;
						end
					endcase
				end
			end
		end
		if (go_data) begin
			next_state = sfra_pkg::ST_DATA;
			next_left = plan.dclk;
			next_lw = plan.dlw;
			next_sh = {plan.wd, 24'h0};
		end
		case (state)
			sfra_pkg::ST_BOOT: next_plan = bp;
			sfra_pkg::ST_IDLE: begin
				if (req_valid) begin
					if (req_direct && !req_write && m != c_last) begin
						next_c_valid = 1'b0;
						next_c_tag = 27'h0;
						next_c_data = 32'h0;
						next_c_last = m;
					end
					if (!ok || hit) begin
						next_done = 1'b1;
						next_err = !ok;
						next_data = ok ? c_data : 32'h0;
					end else begin
						next_plan = fp;
						start = 1'b1;
					end
				end else if (tpm_req) begin
					if (desc_valid) begin
						next_plan = tp;
						start = 1'b1;
					end else begin
						next_done = 1'b1;
						next_err = 1'b1;
						next_data = 32'h0;
					end
				end
			end
			sfra_pkg::ST_TAIL: begin
				next_tail = 2'(tail - 2'h1);
				if (tail == 2'h0) begin
					next_sel_b = 3'h7;
					next_state = sfra_pkg::ST_IDLE;
					if (plan.kind == sfra_pkg::K_BOOT) begin
						if (bidx == 4'h0 && word != sfra_pkg::SIGNATURE) begin
							next_dd = 1'b1;
						end else if (bidx == sfra_pkg::BOOT_LAST) begin
							next_dd = 1'b1;
							next_dv = 1'b1;
						end else begin
							next_bidx = 4'(bidx + 4'h1);
							next_state = sfra_pkg::ST_BOOT;
						end
						if (bidx != 4'h0 && bidx < sfra_pkg::MST_FIRST) begin
							next_base[3'(bidx - 4'h1)] = word[sfra_pkg::RB_HI:0];
							next_lim[3'(bidx - 4'h1)] = word[sfra_pkg::RL_HI:sfra_pkg::RL_LO];
						end
						if (bidx >= sfra_pkg::MST_FIRST)
							next_rid[2'(bidx - sfra_pkg::MST_FIRST)] = word[sfra_pkg::RID_HI:0];
						next_base[0] = 15'h0;
					end else begin
						next_done = 1'b1;
						next_data = plan.din ? word : 32'h0;
						if (plan.kind == sfra_pkg::K_DIR) begin
							next_c_valid = 1'b1;
							next_c_tag = plan.linear_flash_address;
							next_c_data = word;
						end
					end
				end
			end
			default: ;
		endcase
		// Explicit start: a repeated request has the same plan as the last one
		if ((state == sfra_pkg::ST_BOOT) || start) begin
			next_state = sfra_pkg::ST_CMD;
			next_cnt = 4'h0;
			next_left = sfra_pkg::CMD_CLK;
			next_lw = sfra_pkg::LW1;
			next_sh = {next_plan.cmd, 24'h0};
			next_sel_b = ~(3'h1 << next_plan.cs);
		end
		next_ready = next_state == sfra_pkg::ST_IDLE;
		next_io = 4'h0;
		next_oe = 4'h1;
		if (next_state inside {sfra_pkg::ST_CMD, sfra_pkg::ST_ADDR, sfra_pkg::ST_DUMMY, sfra_pkg::ST_DATA}) begin
			next_io = next_lw == sfra_pkg::LW1 ? {3'h0, next_sh[31]}
				: next_lw == sfra_pkg::LW2 ? {2'h0, next_sh[31:30]} : next_sh[31:28];
			if (next_state == sfra_pkg::ST_DATA && next_plan.din)
				next_oe = bidir_strap ? 4'h0 : 4'h1;
			else
				next_oe = lane_mask(next_lw) | 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= sfra_pkg::ST_BOOT;
			plan <= '0;
			cnt <= 4'h0;
			left <= 6'h00;
			lw <= 2'h0;
			sh <= 32'h0;
			shi <= 32'h0;
			cap <= 2'h0;
			tail <= 2'h0;
			bidx <= 4'h0;
			base <= '{default: 15'h0};
			lim <= '{default: 15'h0};
			rid <= '{default: 16'h0};
			c_valid <= 1'b0;
			c_tag <= 27'h0;
			c_data <= 32'h0;
			c_last <= 2'h0;
			req_ready <= 1'b0;
			rsp_done <= 1'b0;
			rsp_err <= 1'b0;
			rsp_data <= 32'h0;
			desc_done <= 1'b0;
			desc_valid <= 1'b0;
			spi_clk <= 1'b0;
			sel_b <= 3'h7;
			io_out <= 4'h0;
			io_oe <= 4'h1;
		end else begin
			state <= next_state;
			plan <= next_plan;
			cnt <= next_cnt;
			left <= next_left;
			lw <= next_lw;
			sh <= next_sh;
			shi <= next_shi;
			cap <= next_cap;
			tail <= next_tail;
			bidx <= next_bidx;
			base <= next_base;
			lim <= next_lim;
			rid <= next_rid;
			c_valid <= next_c_valid;
			c_tag <= next_c_tag;
			c_data <= next_c_data;
			c_last <= next_c_last;
			req_ready <= next_ready;
			rsp_done <= next_done;
			rsp_err <= next_err;
			rsp_data <= next_data;
			desc_done <= next_dd;
			desc_valid <= next_dv;
			spi_clk <= next_sck;
			sel_b <= next_sel_b;
			io_out <= next_io;
			io_oe <= next_oe;
		end
	end
endmodule

// file: testbench/sfra_ctrl_properties.sv
module sfra_ctrl_properties (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       req_valid,
	input wire logic       req_direct,
	input wire logic       req_write,
	input wire logic       req_ready,
	input wire logic       rsp_done,
	input wire logic       rsp_err,
	input wire logic       desc_done,
	input wire logic       desc_valid,
	input wire logic       spi_clk,
	input wire logic       flash_select_primary_b,
	input wire logic       flash_select_secondary_b,
	input wire logic       secure_module_select_b,
	input wire logic [3:0] io_oe,
	input wire logic       bidir_strap,
	input wire logic       tpm_strap_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sel_one_low_a: assert property (
		$onehot0(~{flash_select_primary_b, flash_select_secondary_b, secure_module_select_b}))
		else $error("more than one select low");
	boot_clk_a: assert property ($rose(spi_clk) && !desc_done |-> spi_clk[*4] ##1 !spi_clk)
		else $error("descriptor clock high phase wrong");
	tpm_clk_a: assert property (
		$rose(spi_clk) && !secure_module_select_b && !tpm_strap_valid |-> spi_clk[*2] ##1 !spi_clk)
		else $error("secure clock high phase wrong");
	dir_write_a: assert property (req_valid && req_ready && req_direct && req_write |=> rsp_done && rsp_err)
		else $error("direct write not refused");
	refuse_quiet_a: assert property (rsp_done && rsp_err |->
		$past(flash_select_primary_b) && $past(flash_select_secondary_b) && flash_select_primary_b)
		else $error("refused access reached flash");
	desc_first_a: assert property (!desc_done |-> flash_select_secondary_b && secure_module_select_b)
		else $error("other device selected during descriptor fetch");
	sig_gate_a: assert property (desc_valid |-> desc_done)
		else $error("descriptor valid before fetch done");
	ok_needs_desc_a: assert property (rsp_done && !rsp_err |-> desc_valid)
		else $error("access served without descriptor");
	oe_single_a: assert property (!bidir_strap |-> io_oe[3:1] == 3'h0)
		else $error("extra lane driven without strap");
	tpm_lines_a: assert property (!secure_module_select_b |-> io_oe == 4'h1)
		else $error("secure frame lane enables wrong");
endmodule

bind sfra_ctrl sfra_ctrl_properties sfra_ctrl_properties_inst (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
	.req_direct(req_direct), .req_write(req_write), .req_ready(req_ready), .rsp_done(rsp_done),
	.rsp_err(rsp_err), .desc_done(desc_done), .desc_valid(desc_valid), .spi_clk(spi_clk),
	.flash_select_primary_b(flash_select_primary_b), .flash_select_secondary_b(flash_select_secondary_b),
	.secure_module_select_b(secure_module_select_b), .io_oe(io_oe), .bidir_strap(bidir_strap),
	.tpm_strap_valid(tpm_strap_valid));

// file: testbench/sfra_flash_model.sv
module sfra_flash_model #(
	parameter int LEAD = 40
) (
	input wire logic spi_clk,
	input wire logic sel_b,
	input wire logic mosi,
	output logic     miso
);
	timeunit 1ns;
	timeprecision 1ps;
	int          cnt;
	int          j;
	logic [31:0] sh;
	logic [23:0] a;
	logic [23:0] b;
	logic [31:0] w;

	// ----------------------------------------
	// Descriptor image and fill pattern
	// ----------------------------------------
	function automatic logic [31:0] word(input logic [23:0] x);
		case (x)
			24'h10: return 32'h0ff0a55a;
			24'h44: return 32'h00010001;
			24'h48: return 32'h00020002;
			24'h4c: return 32'h00030003;
			24'h50: return 32'h00000001; // Platform region left invalid
			24'h54: return 32'h00050005;
			24'h40: return 32'h00000000;
			24'h80, 24'h84, 24'h88, 24'h8c: return {16'h0000, 14'h0280, x[3:2]};
			default: return {x[15:0] ^ 16'h5a5a, x[15:0]};
		endcase
	endfunction

	// ----------------------------------------
	// Single-line fast read, 8 dummy clocks
	// ----------------------------------------
	initial miso = 1'h1;
	always @(negedge sel_b) cnt = 0;
	always @(posedge spi_clk) begin
		if (!sel_b) begin
			sh = {sh[30:0], mosi};
			cnt++;
			if (cnt == 32) a = sh[23:0];
		end
	end
	// Released line floats to its pull-up, never keeps the last bit
	always @(negedge spi_clk or posedge sel_b) begin
		if (sel_b || cnt < LEAD) miso = 1'h1;
		else begin
			j = cnt - LEAD;
			b = a + 24'(j / 8);
			w = word({b[23:2], 2'h0}) >> (8 * b[1:0]);
			miso = w[7 - j % 8];
		end
	end
endmodule

// file: testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic d; logic w; logic [1:0] m; logic [15:0] r; logic [26:0] a; logic e; logic [31:0] x;} sfra_row_type;
	logic        clk, rst_b, req_valid, req_direct, req_write, tpm_req, tpm_write, tpm_strap_valid, miso, miso_t;
	logic        req_ready, rsp_done, rsp_err, desc_done, desc_valid, spi_clk, sel0_b, sel1_b, sel2_b;
	logic [1:0]  req_master, flash_clk_sel, tpm_strap_sel;
	logic [15:0] req_rid;
	logic [26:0] req_addr;
	logic [23:0] tpm_addr;
	logic [31:0] rsp_data;
	logic [3:0]  io_in, io_out, io_oe;
	int          errors, num_checks, lat, n;
	sfra_row_type rows [12];

	sfra_ctrl sfra_ctrl_inst (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_direct(req_direct),
		.req_write(req_write), .req_master(req_master), .req_rid(req_rid), .req_addr(req_addr),
		.req_wdata(8'ha5), .tpm_req(tpm_req), .tpm_write(tpm_write), .tpm_addr(tpm_addr), .tpm_wdata(8'h3c),
		.flash_clk_sel(flash_clk_sel), .read_mode(sfra_pkg::RM_DOUT), .bidir_strap(1'h0),
		.addr4_primary(1'h0), .addr4_secondary(1'h0), .tpm_strap_valid(tpm_strap_valid),
		.tpm_strap_sel(tpm_strap_sel), .io_in(io_in), .req_ready(req_ready), .rsp_done(rsp_done),
		.rsp_err(rsp_err), .rsp_data(rsp_data), .desc_done(desc_done), .desc_valid(desc_valid),
		.spi_clk(spi_clk), .flash_select_primary_b(sel0_b), .flash_select_secondary_b(sel1_b),
		.secure_module_select_b(sel2_b), .io_out(io_out), .io_oe(io_oe));
	sfra_flash_model sfra_flash_model_inst (.spi_clk(spi_clk), .sel_b(sel0_b), .mosi(io_out[0]), .miso(miso));
	// Single secure device, no wait states, runs at whatever clock it is given
	sfra_flash_model #(.LEAD(32)) sfra_flash_model_tpm_inst (.spi_clk(spi_clk), .sel_b(sel2_b),
		.mosi(io_out[0]), .miso(miso_t));
	// Undriven pads sit at their pull-ups; idle devices leave the line high
	assign io_in = {io_oe[3] ? io_out[3] : 1'h1, io_oe[2] ? io_out[2] : 1'h1,
		io_oe[1] ? io_out[1] : miso & miso_t, io_oe[0] ? io_out[0] : 1'h1};

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] pat(input logic [26:0] a);
		return {a[15:0] ^ 16'h5a5a, a[15:0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic req(input logic t, input sfra_row_type q);
		lat = 0;
		while (req_ready !== 1'h1) @(negedge clk);
		@(posedge clk);
		req_valid <= !t;
		tpm_req <= t;
		req_direct <= q.d;
		req_write <= q.w;
		tpm_write <= q.w;
		req_master <= q.m;
		req_rid <= q.r;
		req_addr <= q.a;
		tpm_addr <= q.a[23:0];
		@(posedge clk);
		req_valid <= 1'h0;
		tpm_req <= 1'h0;
		while (rsp_done !== 1'h1 && lat < 3000) begin
			@(negedge clk);
			lat++;
		end
		chk("response", 32'h1, rsp_done);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		wrap_up();
	end
	initial begin
		{rst_b, req_valid, req_direct, req_write, tpm_req, tpm_write, tpm_strap_valid} = 7'h00;
		{req_master, flash_clk_sel, tpm_strap_sel, req_rid, req_addr, tpm_addr} = '0;
		rows[0] = '{1'h1, 1'h0, 2'h0, 16'h0a00, 27'h10, 1'h0, pat(27'h1010)};
		rows[1] = '{1'h1, 1'h0, 2'h0, 16'h0bad, 27'h10, 1'h1, 32'h0};
		rows[2] = '{1'h1, 1'h1, 2'h0, 16'h0a00, 27'h10, 1'h1, 32'h0};
		rows[3] = '{1'h1, 1'h0, 2'h0, 16'h0a00, 27'h1000, 1'h1, 32'h0};
		rows[4] = '{1'h1, 1'h0, 2'h2, 16'h0a02, 27'h3000, 1'h0, pat(27'h3000)};
		rows[5] = '{1'h1, 1'h0, 2'h2, 16'h0a02, 27'h1000, 1'h1, 32'h0};
		rows[6] = '{1'h0, 1'h0, 2'h0, 16'h0a00, 27'h5004, 1'h0, pat(27'h5004)};
		rows[7] = '{1'h0, 1'h1, 2'h0, 16'h0a00, 27'h2000, 1'h1, 32'h0};
		rows[8] = '{1'h0, 1'h0, 2'h3, 16'h0a03, 27'h1000, 1'h1, 32'h0};
		rows[9] = '{1'h0, 1'h0, 2'h1, 16'h0bad, 27'h2000, 1'h1, 32'h0};
		rows[10] = '{1'h0, 1'h1, 2'h0, 16'h0a00, 27'h1004, 1'h0, 32'h0};
		rows[11] = '{1'h1, 1'h0, 2'h1, 16'h0a01, 27'h20, 1'h0, pat(27'h2020)};
		repeat (16) @(posedge clk);
		chk("selects in reset", 32'h7, {sel0_b, sel1_b, sel2_b});
		chk("oe in reset", 32'h1, io_oe);
		rst_b <= 1'h1;
		for (n = 0; n < 20000 && desc_done !== 1'h1; n++) @(negedge clk);
		chk("descriptor valid", 32'h1, desc_valid);
		foreach (rows[i]) begin
			flash_clk_sel <= 2'(i); // Clock codes 0, 2 and 3 carry transfers; code 1 falls only on refused rows
			req(1'h0, rows[i]);
			chk("refused", rows[i].e, rsp_err);
			if (!rows[i].e && !rows[i].w) chk("read data", rows[i].x, rsp_data);
		end
		req(1'h0, rows[11]);
		chk("hit fast", 32'h1, lat < 4);
		chk("hit data", rows[11].x, rsp_data);
		req(1'h0, rows[0]);
		chk("host data", rows[0].x, rsp_data);
		req(1'h0, rows[11]);
		chk("refetch slow", 32'h1, lat > 20);
		chk("refetch data", rows[11].x, rsp_data);
		for (n = 0; n < 2; n++) begin
			tpm_strap_valid <= n[0];
			tpm_strap_sel <= 2'h2;
			req(1'h1, rows[0]);
			chk("secure byte", 32'h05a, {rsp_err, rsp_data[7:0]});
		end
		// Mid-run reset must restart the descriptor fetch
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		chk("status in reset", 32'h0, {req_ready, rsp_done, desc_done, desc_valid, spi_clk});
		chk("selects in reset", 32'h7, {sel0_b, sel1_b, sel2_b});
		rst_b <= 1'h1;
		for (n = 0; n < 20000 && desc_done !== 1'h1; n++) @(negedge clk);
		chk("descriptor again", 32'h1, desc_valid);
		req(1'h0, rows[6]);
		chk("read after reset", rows[6].x, rsp_data);
		wrap_up();
	end
endmodule
